// ==== pkg/psm_pkg.sv ====
// Shared constants for the bus port slave/master pair
// Operation
// - Null-enable write phase disconnects the transfer
// - External writer enables a byte every phase
// - Null-enable read phase answers with target abort
// - External reader enables lanes, never retries aborts
// - Each burst word lands at its own address
// - Long bursts only under strict system conditions
// - Master, target, software stop abort master transfer
// - Completion flag only after true master completion
// - Software checks start bits before trusting completion
// - Port stays usable after abort; reset recovers it
// - Never write one to cache line size
// - Slave read retries, then prefetches thirty-two words
package psm_pkg;
  localparam int unsigned DW    = 32;
  localparam int unsigned BEW   = 4;
  localparam int unsigned RAW   = 8;
  localparam int unsigned RESPW = 2;
  localparam int unsigned STW   = 8;
  localparam int unsigned HLW   = 4;
  localparam int unsigned PF_WORDS   = 32;
  localparam int unsigned SAFE_BURST = 4;
  localparam int unsigned WORD_SHIFT = 2;

  // Register offsets
  localparam logic [RAW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [RAW-1:0] OFS_MADDR  = 8'h04;
  localparam logic [RAW-1:0] OFS_MWDATA = 8'h08;
  localparam logic [RAW-1:0] OFS_MRDATA = 8'h0C;
  localparam logic [RAW-1:0] OFS_STATUS = 8'h10;
  localparam logic [RAW-1:0] OFS_MASK   = 8'h14;
  localparam logic [RAW-1:0] OFS_INFO   = 8'h18;

  // Control fields: start code in the low two bits
  localparam int unsigned CTRL_PRST = 2;
  localparam logic [1:0] START_IDLE = 2'h0;
  localparam logic [1:0] START_WR   = 2'h1;
  localparam logic [1:0] START_RD   = 2'h2;

  // Answer codes of the far target
  localparam logic [RESPW-1:0] RESP_OK   = 2'h0;
  localparam logic [RESPW-1:0] RESP_MABT = 2'h1;
  localparam logic [RESPW-1:0] RESP_TABT = 2'h2;

  // Status bit positions
  localparam int unsigned ST_NULLWR  = 0;
  localparam int unsigned ST_SLVTABT = 1;
  localparam int unsigned ST_MABT    = 2;
  localparam int unsigned ST_TABT    = 3;
  localparam int unsigned ST_SWABT   = 4;
  localparam int unsigned ST_DONE    = 6;

  localparam logic [BEW-1:0] BE_NONE = 4'h0;
  localparam logic [BEW-1:0] BE_ALL  = 4'hF;
  localparam logic [HLW-1:0] MAX_RETRY_DEF = 4'h8;
endpackage

// ==== pkg/psm_link_if.sv ====
// Link between the external bus master and the device port
`timescale 1ns/100ps
interface psm_link_if (
  input wire logic lclk
);
  logic                          frame;
  logic                          cmd_wr;
  logic                          irdy;
  logic [psm_pkg::BEW-1:0]       be;
  logic [psm_pkg::DW-1:0]        addr;
  logic [psm_pkg::DW-1:0]        wdata;
  logic [psm_pkg::DW-1:0]        rdata;
  logic                          trdy;
  logic                          stop;
  logic                          tabort;
  logic                          m_req;
  logic                          m_wr;
  logic [psm_pkg::DW-1:0]        m_addr;
  logic [psm_pkg::DW-1:0]        m_wdata;
  logic                          m_ack;
  logic [psm_pkg::RESPW-1:0]     m_resp;
  logic [psm_pkg::DW-1:0]        m_rdata;

  modport dev (input lclk, frame, cmd_wr, irdy, be, addr, wdata,
               m_ack, m_resp, m_rdata,
               output rdata, trdy, stop, tabort, m_req, m_wr, m_addr,
               m_wdata);
  modport host (input lclk, rdata, trdy, stop, tabort, m_req, m_wr,
                m_addr, m_wdata,
                output frame, cmd_wr, irdy, be, addr, wdata, m_ack,
                m_resp, m_rdata);
endinterface

// ==== verilog/psm_sync.sv ====
// Two-stage synchroniser for link inputs with link clock edge finder
`timescale 1ns/100ps
module psm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         lclk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic              rise
);
  import psm_pkg::*;

  typedef struct packed {
    logic [W:0] s1;
    logic [W:0] s2;
    logic       prev;
  } psm_sync_st_t;

  psm_sync_st_t r_reg;
  psm_sync_st_t r_next;

  // First stage feeds only the second stage
  always_comb begin
    r_next      = r_reg;
    r_next.s1   = {lclk, d};
    r_next.s2   = r_reg.s1;
    r_next.prev = r_reg.s2[W];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign q    = r_reg.s2[W-1:0];
  assign rise = r_reg.s2[W] & ~r_reg.prev;
endmodule

// ==== verilog/psm_dev.sv ====
// Device end of the bus port: target with prefetch, master requester
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
module psm_dev #(
  parameter int unsigned MEM_WORDS = 64,
  parameter int unsigned PF_DEPTH  = psm_pkg::PF_WORDS
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  psm_link_if.dev                      lk,
  input  wire logic [psm_pkg::RAW-1:0] reg_addr,
  input  wire logic [psm_pkg::DW-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [psm_pkg::DW-1:0]  reg_rdata,
  output logic                         irq
);
  import psm_pkg::*;

  localparam int unsigned AW  = $clog2(MEM_WORDS);
  localparam int unsigned PFW = $clog2(PF_DEPTH);
  localparam int unsigned SW  = 3 + BEW + 3 * DW + 1 + RESPW;
  localparam logic [PFW:0] PF_LAST = (PFW + 1)'(PF_DEPTH - 1);
  localparam logic [PFW:0] PF_FULL = (PFW + 1)'(PF_DEPTH);

  typedef enum logic {M_IDLE, M_REQ} psm_mst_t;

  typedef struct packed {
    logic [MEM_WORDS-1:0][DW-1:0] mem;
    logic [PF_DEPTH-1:0][DW-1:0]  pf;
    logic [PFW:0]                 pf_cnt;
    logic                         pf_busy;
    logic                         pf_ok;
    logic [DW-1:0]                pf_base;
    logic                         in_txn;
    logic [DW-1:0]                t_base;
    logic [PFW:0]                 idx;
    logic                         trdy;
    logic                         stop;
    logic                         tabort;
    logic [DW-1:0]                rdata;
    psm_mst_t                     mst;
    logic                         m_req;
    logic [1:0]                   start;
    logic [DW-1:0]                maddr;
    logic [DW-1:0]                mwdata;
    logic [DW-1:0]                mrdata;
    logic [STW-1:0]               status;
    logic [STW-1:0]               mask;
    logic [DW-1:0]                rd;
  } psm_dev_st_t;

  psm_dev_st_t r_reg;
  psm_dev_st_t r_next;

  logic [SW-1:0]    s_q;
  logic             edge_seen;
  logic             f_frame;
  logic             f_wr;
  logic             f_irdy;
  logic [BEW-1:0]   f_be;
  logic [DW-1:0]    f_addr;
  logic [DW-1:0]    f_wdata;
  logic             f_ack;
  logic [RESPW-1:0] f_resp;
  logic [DW-1:0]    f_mrdata;

  // Memory word index of a burst word
  function automatic logic [AW-1:0] word_idx(input logic [DW-1:0] base,
                                             input logic [PFW:0]  off);
    word_idx = base[AW+WORD_SHIFT-1:WORD_SHIFT] + AW'(off);
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [DW-1:0] be_merge(input logic [DW-1:0]  old,
                                             input logic [DW-1:0]  nw,
                                             input logic [BEW-1:0] be);
    be_merge = old;
    for (int i = 0; i < BEW; i++) begin
      if (be[i]) begin
        be_merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // All link inputs cross on the same two stages
  psm_sync #(
    .W(SW)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .lclk    (lk.lclk),
    .d       ({lk.frame, lk.cmd_wr, lk.irdy, lk.be, lk.addr, lk.wdata,
               lk.m_ack, lk.m_resp, lk.m_rdata}),
    .q       (s_q),
    .rise    (edge_seen)
  );

  assign {f_frame, f_wr, f_irdy, f_be, f_addr, f_wdata,
          f_ack, f_resp, f_mrdata} = s_q;

  always_comb begin
    logic [STW-1:0] st_set;
    logic [STW-1:0] st_clr;
    logic [DW-1:0]  base;
    logic [PFW:0]   ix;
    logic [AW-1:0]  wi;
    logic [DW-1:0]  rv;
    logic [1:0]     wstart;
    st_set  = '0;
    st_clr  = '0;
    base    = r_reg.t_base;
    ix      = r_reg.idx;
    wi      = '0;
    rv      = '0;
    wstart  = reg_wdata[1:0];
    r_next  = r_reg;
    r_next.rd = '0;

    // Prefetch fill, one word per cycle while the master waits
    if (r_reg.pf_busy) begin
      r_next.pf[r_reg.pf_cnt[PFW-1:0]] =
        r_reg.mem[word_idx(r_reg.pf_base, r_reg.pf_cnt)];
      r_next.pf_cnt = r_reg.pf_cnt + 1'b1;
      if (r_reg.pf_cnt == PF_LAST) begin
        r_next.pf_busy = 1'b0;
        r_next.pf_ok   = 1'b1;
      end
    end

    // Target side: one answer per data phase, cleared next edge
    if (edge_seen) begin
      if (!f_frame) begin
        r_next.in_txn = 1'b0;
        r_next.trdy   = 1'b0;
        r_next.stop   = 1'b0;
        r_next.tabort = 1'b0;
      end else if (r_reg.trdy | r_reg.stop | r_reg.tabort) begin
        r_next.trdy   = 1'b0;
        r_next.stop   = 1'b0;
        r_next.tabort = 1'b0;
      end else if (f_irdy) begin
        if (!r_reg.in_txn) begin
          base          = f_addr;
          ix            = '0;
          r_next.in_txn = 1'b1;
          r_next.t_base = f_addr;
          r_next.idx    = '0;
        end
        if (f_wr) begin
          if (f_be == BE_NONE) begin
            r_next.stop       = 1'b1;
            st_set[ST_NULLWR] = 1'b1;
          end else begin
            wi = word_idx(base, ix);
            r_next.mem[wi] = be_merge(r_reg.mem[wi], f_wdata, f_be);
            r_next.trdy    = 1'b1;
            r_next.idx     = ix + 1'b1;
            // Stale prefetch would return old data
            r_next.pf_ok   = 1'b0;
            r_next.pf_busy = 1'b0;
          end
        end else if (f_be == BE_NONE) begin
          r_next.tabort      = 1'b1;
          st_set[ST_SLVTABT] = 1'b1;
        end else if (r_reg.pf_ok && r_reg.pf_base == base &&
                     ix < PF_FULL) begin
          r_next.rdata = r_reg.pf[ix[PFW-1:0]];
          r_next.trdy  = 1'b1;
          r_next.idx   = ix + 1'b1;
        end else begin
          // Retry now, supply the repeated read from the buffer
          r_next.stop = 1'b1;
          if (!r_reg.pf_busy) begin
            r_next.pf_busy = 1'b1;
            r_next.pf_cnt  = '0;
            r_next.pf_base = base;
            r_next.pf_ok   = 1'b0;
          end
        end
      end
    end

    // Master side; a stale answer must drain before a new request
    if (edge_seen) begin
      unique case (r_reg.mst)
        M_IDLE: begin
          if (r_reg.start != START_IDLE && !f_ack) begin
            r_next.m_req = 1'b1;
            r_next.mst   = M_REQ;
          end
        end
        M_REQ: begin
          if (f_ack) begin
            r_next.m_req = 1'b0;
            r_next.mst   = M_IDLE;
            r_next.start = START_IDLE;
            if (f_resp == RESP_OK) begin
              st_set[ST_DONE] = 1'b1;
              if (r_reg.start == START_RD) begin
                r_next.mrdata = f_mrdata;
              end
            end else if (f_resp == RESP_MABT) begin
              st_set[ST_MABT] = 1'b1;
            end else begin
              st_set[ST_TABT] = 1'b1;
            end
          end
        end
      endcase
    end

    // Register writes override link updates of the same cycle
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL: begin
          if (reg_wdata[CTRL_PRST]) begin
            // Port reset: link state back to idle, memory kept
            r_next.in_txn  = 1'b0;
            r_next.trdy    = 1'b0;
            r_next.stop    = 1'b0;
            r_next.tabort  = 1'b0;
            r_next.idx     = '0;
            r_next.pf_busy = 1'b0;
            r_next.pf_ok   = 1'b0;
            r_next.mst     = M_IDLE;
            r_next.m_req   = 1'b0;
            r_next.start   = START_IDLE;
          end else if (wstart == START_IDLE) begin
            if (r_reg.mst == M_REQ) begin
              r_next.m_req     = 1'b0;
              r_next.mst       = M_IDLE;
              st_set[ST_SWABT] = 1'b1;
            end
            r_next.start = START_IDLE;
          end else if (r_reg.mst == M_IDLE &&
                       (wstart == START_WR || wstart == START_RD)) begin
            r_next.start = wstart;
          end
        end
        OFS_MADDR:  r_next.maddr  = reg_wdata;
        OFS_MWDATA: r_next.mwdata = reg_wdata;
        OFS_MASK:   r_next.mask   = reg_wdata[STW-1:0];
        default: ;
      endcase
    end

    // Register reads, data valid the next cycle only
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL:   rv = DW'(r_reg.start);
        OFS_MADDR:  rv = r_reg.maddr;
        OFS_MWDATA: rv = r_reg.mwdata;
        OFS_MRDATA: rv = r_reg.mrdata;
        OFS_STATUS: begin
          rv     = DW'(r_reg.status);
          st_clr = r_reg.status;
        end
        OFS_MASK:   rv = DW'(r_reg.mask);
        OFS_INFO:   rv = DW'({r_reg.in_txn, r_reg.pf_ok, r_reg.pf_busy,
                              r_reg.mst == M_REQ});
        default:    rv = '0;
      endcase
      r_next.rd = rv;
    end

    // Set wins over read clear
    r_next.status = (r_reg.status & ~st_clr) | st_set;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // Link and software outputs
  assign lk.rdata   = r_reg.rdata;
  assign lk.trdy    = r_reg.trdy;
  assign lk.stop    = r_reg.stop;
  assign lk.tabort  = r_reg.tabort;
  assign lk.m_req   = r_reg.m_req;
  assign lk.m_wr    = (r_reg.start == START_WR);
  assign lk.m_addr  = r_reg.maddr;
  assign lk.m_wdata = r_reg.mwdata;
  assign reg_rdata  = r_reg.rd;
  assign irq        = |(r_reg.status & r_reg.mask);
endmodule

// ==== verilog/psm_host.sv ====
// External end: burst master toward the port, target for its requests
`timescale 1ns/100ps
module psm_host #(
  parameter logic [psm_pkg::HLW-1:0] MAX_BURST =
    psm_pkg::HLW'(psm_pkg::SAFE_BURST),
  parameter logic [psm_pkg::HLW-1:0] MAX_RETRY = psm_pkg::MAX_RETRY_DEF
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  psm_link_if.host                       lk,
  input  wire logic                      go,
  input  wire logic                      go_wr,
  input  wire logic [psm_pkg::DW-1:0]    go_addr,
  input  wire logic [psm_pkg::HLW-1:0]   go_len,
  input  wire logic [psm_pkg::DW-1:0]    go_wdata,
  input  wire logic [psm_pkg::BEW-1:0]   go_be,
  output logic                           busy,
  output logic                           done,
  output logic                           err,
  output logic      [psm_pkg::DW-1:0]    rdata,
  output logic                           rvalid,
  input  wire logic [psm_pkg::RESPW-1:0] tgt_resp,
  input  wire logic [psm_pkg::DW-1:0]    tgt_rdata,
  output logic                           tgt_hit,
  output logic                           tgt_wr,
  output logic      [psm_pkg::DW-1:0]    tgt_addr,
  output logic      [psm_pkg::DW-1:0]    tgt_wdata
);
  import psm_pkg::*;

  localparam int unsigned SW = 3 + 3 * DW + 2;

  typedef enum logic [1:0] {H_IDLE, H_START, H_WAIT} psm_hst_t;

  typedef struct packed {
    psm_hst_t         st;
    logic             frame;
    logic             irdy;
    logic             wr;
    logic [BEW-1:0]   be;
    logic [DW-1:0]    addr;
    logic [DW-1:0]    wdata;
    logic [DW-1:0]    wbase;
    logic [HLW-1:0]   len;
    logic [HLW-1:0]   idx;
    logic [HLW-1:0]   tries;
    logic             done;
    logic             err;
    logic [DW-1:0]    rdata;
    logic             rvalid;
    logic             m_ack;
    logic [RESPW-1:0] m_resp;
    logic [DW-1:0]    m_rdata;
    logic             tgt_hit;
    logic             tgt_wr;
    logic [DW-1:0]    tgt_addr;
    logic [DW-1:0]    tgt_wdata;
  } psm_host_st_t;

  psm_host_st_t r_reg;
  psm_host_st_t r_next;

  logic [SW-1:0] s_q;
  logic          edge_seen;
  logic          s_trdy;
  logic          s_stop;
  logic          s_tabort;
  logic [DW-1:0] s_rdata;
  logic          s_mreq;
  logic          s_mwr;
  logic [DW-1:0] s_maddr;
  logic [DW-1:0] s_mwdata;

  psm_sync #(
    .W(SW)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .lclk    (lk.lclk),
    .d       ({lk.trdy, lk.stop, lk.tabort, lk.rdata, lk.m_req, lk.m_wr,
               lk.m_addr, lk.m_wdata}),
    .q       (s_q),
    .rise    (edge_seen)
  );

  assign {s_trdy, s_stop, s_tabort, s_rdata, s_mreq, s_mwr, s_maddr,
          s_mwdata} = s_q;

  always_comb begin
    logic [HLW-1:0] nx;
    nx             = r_reg.idx + 1'b1;
    r_next         = r_reg;
    r_next.done    = 1'b0;
    r_next.rvalid  = 1'b0;
    r_next.tgt_hit = 1'b0;

    // Burst master, one phase per answer
    unique case (r_reg.st)
      H_IDLE: begin
        if (go) begin
          r_next.wr    = go_wr;
          r_next.addr  = go_addr;
          r_next.wdata = go_wdata;
          r_next.wbase = go_wdata;
          // Never a null lane set
          r_next.be    = (go_be == BE_NONE) ? BE_ALL : go_be;
          // Stay within the safe burst length
          if (go_len > MAX_BURST) begin
            r_next.len = MAX_BURST;
          end else if (go_len == '0) begin
            r_next.len = HLW'(1);
          end else begin
            r_next.len = go_len;
          end
          r_next.idx   = '0;
          r_next.tries = '0;
          r_next.err   = 1'b0;
          r_next.st    = H_START;
        end
      end
      H_START: begin
        if (edge_seen) begin
          r_next.frame = 1'b1;
          r_next.irdy  = 1'b1;
          r_next.st    = H_WAIT;
        end
      end
      H_WAIT: begin
        if (edge_seen) begin
          if (s_trdy) begin
            if (!r_reg.wr) begin
              r_next.rdata  = s_rdata;
              r_next.rvalid = 1'b1;
            end
            r_next.idx   = nx;
            r_next.wdata = r_reg.wbase + DW'(nx);
            if (nx == r_reg.len) begin
              r_next.frame = 1'b0;
              r_next.irdy  = 1'b0;
              r_next.done  = 1'b1;
              r_next.st    = H_IDLE;
            end
          end else if (s_tabort) begin
            // Aborted reads are given up, not repeated
            r_next.frame = 1'b0;
            r_next.irdy  = 1'b0;
            r_next.err   = 1'b1;
            r_next.done  = 1'b1;
            r_next.st    = H_IDLE;
          end else if (s_stop) begin
            r_next.frame = 1'b0;
            r_next.irdy  = 1'b0;
            if (r_reg.tries == MAX_RETRY) begin
              r_next.err  = 1'b1;
              r_next.done = 1'b1;
              r_next.st   = H_IDLE;
            end else begin
              // Resume at the first word not yet taken
              r_next.tries = r_reg.tries + 1'b1;
              r_next.addr  = r_reg.addr + (DW'(r_reg.idx) << WORD_SHIFT);
              r_next.wbase = r_reg.wdata;
              r_next.len   = r_reg.len - r_reg.idx;
              r_next.idx   = '0;
              r_next.st    = H_START;
            end
          end
        end
      end
      default: r_next.st = H_IDLE;
    endcase

    // Target for the port's own requests, four-phase on ack
    if (edge_seen) begin
      if (s_mreq && !r_reg.m_ack) begin
        r_next.m_ack     = 1'b1;
        r_next.m_resp    = tgt_resp;
        r_next.m_rdata   = tgt_rdata;
        r_next.tgt_hit   = 1'b1;
        r_next.tgt_wr    = s_mwr;
        r_next.tgt_addr  = s_maddr;
        r_next.tgt_wdata = s_mwdata;
      end else if (!s_mreq && r_reg.m_ack) begin
        r_next.m_ack = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign lk.frame   = r_reg.frame;
  assign lk.cmd_wr  = r_reg.wr;
  assign lk.irdy    = r_reg.irdy;
  assign lk.be      = r_reg.be;
  assign lk.addr    = r_reg.addr;
  assign lk.wdata   = r_reg.wdata;
  assign lk.m_ack   = r_reg.m_ack;
  assign lk.m_resp  = r_reg.m_resp;
  assign lk.m_rdata = r_reg.m_rdata;
  assign busy       = (r_reg.st != H_IDLE);
  assign done       = r_reg.done;
  assign err        = r_reg.err;
  assign rdata      = r_reg.rdata;
  assign rvalid     = r_reg.rvalid;
  assign tgt_hit    = r_reg.tgt_hit;
  assign tgt_wr     = r_reg.tgt_wr;
  assign tgt_addr   = r_reg.tgt_addr;
  assign tgt_wdata  = r_reg.tgt_wdata;
endmodule

// ==== tb/psm_link_sva.sv ====
// Link protocol checker for the host and device ends of the bus port
`timescale 1ns/100ps
module psm_link_sva (
  input logic                    clk_sys,
  input logic                    rst_n,
  input logic                    frame,
  input logic                    cmd_wr,
  input logic                    irdy,
  input logic [psm_pkg::BEW-1:0] be,
  input logic                    trdy,
  input logic                    stop,
  input logic                    tabort,
  input logic                    m_req,
  input logic                    m_ack
);
  import psm_pkg::*;
  logic       trdy_reg;
  logic [3:0] wcnt_reg;
  // Words taken in one write frame; a retry frame counts afresh
  always_ff @(posedge clk_sys) begin
    trdy_reg <= trdy;
    if (!rst_n || !frame) begin
      wcnt_reg <= 4'h0;
    end else if (trdy && !trdy_reg && cmd_wr) begin
      wcnt_reg <= wcnt_reg + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_be_lane:
    assert property (frame && irdy |-> be != BE_NONE)
    else $error("phase without byte enable");
  a_abort_null:
    assert property ($rose(tabort) |-> !cmd_wr && be == BE_NONE)
    else $error("target abort on a live read");
  a_accept_lane:
    assert property ($rose(trdy) |-> frame && irdy && be != BE_NONE)
    else $error("phase accepted outside rules");
  a_burst_max:
    assert property (wcnt_reg <= 4'h4)
    else $error("write burst too long");
  a_ack_req:
    assert property ($rose(m_ack) |-> $past(m_req))
    else $error("ack without request");
  a_req_drop:
    assert property ($rose(m_ack) |-> ##[1:40] !m_req)
    else $error("request held after ack");
  a_req_fresh:
    assert property ($rose(m_req) |-> !m_ack)
    else $error("request over stale ack");
  a_retry_drop:
    assert property ($rose(stop) |-> ##[1:40] !frame)
    else $error("frame kept after disconnect");
endmodule

// ==== tb/psm_tb.sv ====
// Bench joining the host end and the device end over the link
`timescale 1ns/100ps
module psm_tb;
  import psm_pkg::*;
  logic clk_sys = 1'b0, lclk = 1'b0, rst_n = 1'b0, irq, done, rvalid;
  logic host_ce = 1'b1, busy, err, tgt_wr;
  logic [3:0] go_len = 4'h4;
  logic reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, go_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, go_addr = 32'h0, go_wdata = 32'h0;
  logic [31:0] tgt_rdata = 32'h0, reg_rdata, rdata, tgt_addr, tgt_wdata;
  logic [3:0] go_be = 4'hF;
  logic [1:0] tgt_resp = 2'h0;
  logic [1:0] rs[4] = '{RESP_OK, RESP_MABT, RESP_TABT, RESP_OK};
  logic [7:0] es[4] = '{8'h40, 8'h04, 8'h08, 8'h40};
  int err_total = 0;
  int n_compared = 0;
  // Unrelated clocks for the system and the link
  always #2.5 clk_sys = ~clk_sys;
  always #24 lclk = ~lclk;
  psm_link_if lk (.lclk);
  psm_dev i_psm_dev (.clk_sys, .rst_n, .ce(1'b1), .lk, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  psm_host i_psm_host (.clk_sys, .rst_n, .ce(host_ce), .lk, .go, .go_wr,
    .go_addr, .go_len, .go_wdata, .go_be, .busy, .done, .err,
    .rdata, .rvalid, .tgt_resp, .tgt_rdata, .tgt_hit(), .tgt_wr,
    .tgt_addr, .tgt_wdata);
  psm_link_sva i_psm_link_sva (.clk_sys, .rst_n, .frame(lk.frame),
    .cmd_wr(lk.cmd_wr), .irdy(lk.irdy), .be(lk.be), .trdy(lk.trdy),
    .stop(lk.stop), .tabort(lk.tabort), .m_req(lk.m_req),
    .m_ack(lk.m_ack));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Register port: one-cycle strobes, read data the cycle after
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Byte merge; the host end widens an empty enable to all lanes
  function automatic logic [31:0] mrg(logic [31:0] o, n, logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      if (b[i] || b == 4'h0) o[8*i+:8] = n[8*i+:8];
    end
    return o;
  endfunction
  // One four-word burst from the host end, read words collected
  task automatic run(logic w, logic [31:0] a, d, logic [3:0] b,
                     output logic [31:0] q[4]);
    int k;
    k = 0;
    q = '{default: 'x};
    @(posedge clk_sys);
    go <= 1'b1;
    go_wr <= w;
    go_addr <= a;
    go_wdata <= d;
    go_be <= b;
    // Asks of four words or more, all clipped to the safe length
    go_len <= 4'($urandom) | 4'h4;
    @(posedge clk_sys);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 3000 && !done; i++) begin
      @(posedge clk_sys);
      #1 if (rvalid && k < 4) q[k++] = rdata;
    end
    chk("done", {31'h0, done}, 32'h1);
    chk("idle", {30'h0, busy, err}, 32'h0);
  endtask
  task automatic bursts();
    logic [31:0] a, d, e, q[4];
    logic [3:0] b;
    for (int t = 0; t < 3; t++) begin
      a = $urandom & 32'hFC;
      d = $urandom;
      e = $urandom;
      b = (t == 0) ? BE_NONE : 4'($urandom);
      run(1'b1, a, d, BE_ALL, q);
      run(1'b1, a, e, b, q);
      run(1'b0, a, d, BE_ALL, q);
      for (int i = 0; i < 4; i++) begin
        chk("word", q[i], mrg(d + i, e + i, b));
      end
    end
    rd(OFS_STATUS, d);
    chk("status", d, 32'h0);
    $display("test bursts done");
  endtask
  // Master requests: software stop, success, both aborts, then success with done masked
  task automatic mst();
    logic [31:0] v, d, a;
    logic [1:0] c;
    // Far end frozen, so no ack can race the software stop
    @(posedge clk_sys);
    host_ce <= 1'b0;
    wr(OFS_CTRL, 32'h2);
    d = 32'h0;
    for (int i = 0; i < 99 && d[0] !== 1'b1; i++) rd(OFS_INFO, d);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, d);
    chk("swabort", d, 32'h10);
    @(posedge clk_sys);
    host_ce <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      v = $urandom;
      a = $urandom;
      c = (t == 1) ? START_WR : START_RD;
      @(posedge clk_sys);
      tgt_resp <= rs[t];
      tgt_rdata <= v;
      wr(OFS_MASK, (t == 3) ? 32'h0C : 32'h4C);
      wr(OFS_MADDR, a);
      wr(OFS_MWDATA, ~a);
      wr(OFS_CTRL, {30'h0, c});
      d = 32'h2;
      for (int i = 0; i < 99 && d[1:0] != 2'h0; i++) rd(OFS_CTRL, d);
      chk("start", d & 32'h3, 32'h0);
      @(posedge clk_sys);
      #1 chk("irq", {31'h0, irq}, {31'h0, t != 3});
      rd(OFS_STATUS, d);
      chk("status", d, {24'h0, es[t]});
      chk("taddr", tgt_addr, a);
      chk("twdata", tgt_wdata, ~a);
      chk("twr", {31'h0, tgt_wr}, {31'h0, c == START_WR});
      rd(OFS_MRDATA, d);
      if (rs[t] == RESP_OK) chk("mrdata", d, v);
    end
    $display("test master done");
  endtask
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
  initial begin
    logic [31:0] d;
    void'($urandom(32'h35F43BF4));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    bursts();
    mst();
    bursts();
    rd(8'h1C, d);
    chk("unmapped", d, 32'h0);
    // Port reset must leave the link fit for service
    wr(OFS_CTRL, 32'h4);
    bursts();
    stop_test();
  end
endmodule
